// file: rtl/spl_pkg.sv
// Package of register offsets, field positions and reset values for the shared port pin logic
`default_nettype none
package spl_pkg;
  // ****************************************************
  // Register byte offsets
  // ****************************************************
  localparam logic [7:0] SPL_OFF_DATA    = 8'h00;
  localparam logic [7:0] SPL_OFF_DIR     = 8'h04;
  localparam logic [7:0] SPL_OFF_PULLUP  = 8'h08;
  localparam logic [7:0] SPL_OFF_ANALOG  = 8'h0C;
  localparam logic [7:0] SPL_OFF_OPTION  = 8'h10;
  localparam logic [7:0] SPL_OFF_IRQ_ST  = 8'h14;
  localparam logic [7:0] SPL_OFF_IRQ_MSK = 8'h18;
  localparam logic [7:0] SPL_OFF_PINS    = 8'h1C;
  // ****************************************************
  // Field positions and widths
  // ****************************************************
  localparam int SPL_NPIN       = 8;
  localparam int SPL_NANA       = 4;
  localparam int SPL_POS_OSC_A  = 2;
  localparam int SPL_POS_OSC_B  = 3;
  localparam int SPL_POS_IRQ_A  = 1;
  localparam int SPL_POS_IRQ_B  = 5;
  localparam int SPL_POS_RST    = 4;
  localparam int SPL_POS_OPT_PORT = 0;
  localparam int SPL_POS_BOOTED = 1;
  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0] SPL_RST_DATA   = 8'h00;
  localparam logic [7:0] SPL_RST_DIR    = 8'hFF;
  localparam logic [7:0] SPL_RST_PULLUP = 8'h00;
  localparam logic [3:0] SPL_RST_ANALOG = 4'h0;
  localparam logic [1:0] SPL_RST_IRQ    = 2'h0;
  localparam logic [31:0] SPL_ERR_NONE  = 32'h0000_0000;
  // ****************************************************
  // Boot sequencer states
  // ****************************************************
  typedef enum logic [2:0] {
    SPL_ST_HOLD = 3'b001,
    SPL_ST_LOAD = 3'b010,
    SPL_ST_RUN  = 3'b100
  } spl_state_t;
endpackage
`default_nettype wire

// file: rtl/spl_port.sv
// Shared-function port pin logic with APB register access
//
// The implementer's own choices: the address map and the APB register port.
`default_nettype none
module spl_port
  import spl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [7:0]  option_byte,
  input  wire logic        option_valid,
  input  wire logic [7:0]  pin_in,
  output var  logic [7:0]  pin_out,
  output var  logic [7:0]  pin_oe,
  output var  logic [7:0]  pin_pullup,
  output var  logic [1:0]  pin_pulldown,
  output var  logic [3:0]  converter_select,
  output var  logic        core_reset_n,
  output var  logic        irq
);
  // ****************************************************
  // State
  // ****************************************************
  logic [7:0]  latch_q, latch_d;
  logic [7:0]  dir_q, dir_d;
  logic [7:0]  pullup_q, pullup_d;
  logic [3:0]  analog_q, analog_d;
  logic        port_mode_q, port_mode_d;
  logic [1:0]  irq_st_q, irq_st_d;
  logic [1:0]  irq_msk_q, irq_msk_d;
  logic [31:0] prdata_d;
  logic        pready_d, pslverr_d;
  logic [7:0]  out_d, oe_d, pu_d;
  logic [1:0]  pd_d;
  logic [3:0]  conv_d;
  logic        core_d, irq_d;
  logic [1:0]  edge_prev_q, edge_prev_d;
  spl_state_t  st_q, st_d;
  logic [7:0]  pin_sync;
  logic [7:0]  pin_view;
  logic        access, wr, rd;
  logic [1:0]  irq_lvl;

  spl_sync #(.W(SPL_NPIN)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .level_q  (pin_sync)
  );

  assign access  = psel && penable && !pready;
  assign wr      = access && pwrite;
  assign rd      = access && !pwrite;
  // Driven level on each interrupt-shared pin, or its sampled input level
  assign irq_lvl = {dir_q[SPL_POS_IRQ_B] ? pin_sync[SPL_POS_IRQ_B] : latch_q[SPL_POS_IRQ_B],
                    dir_q[SPL_POS_IRQ_A] ? pin_sync[SPL_POS_IRQ_A] : latch_q[SPL_POS_IRQ_A]};

  // ****************************************************
  // Pin view
  // ****************************************************
  genvar i;
  generate
    for (i = 0; i < SPL_NPIN; i++) begin : g_pin
      assign pin_view[i] = dir_q[i] ? pin_sync[i] : latch_q[i];
    end
  endgenerate

  // ****************************************************
  // Boot sequencer
  // ****************************************************
  always_comb begin
    st_d        = st_q;
    port_mode_d = port_mode_q;
    case (st_q)
      SPL_ST_HOLD: begin
        st_d = SPL_ST_LOAD;
      end
      SPL_ST_LOAD: begin
        if (option_valid && pin_sync[SPL_POS_RST]) begin
          port_mode_d = option_byte[SPL_POS_OPT_PORT];
          st_d        = SPL_ST_RUN;
        end
      end
      SPL_ST_RUN: begin
        // external reset only when not a port
        if (!port_mode_q && !pin_sync[SPL_POS_RST]) begin
          st_d = SPL_ST_LOAD;
        end
      end
      default: st_d = SPL_ST_HOLD;
    endcase
  end

  // ****************************************************
  // Register file
  // ****************************************************
  always_comb begin
    latch_d     = latch_q;
    dir_d       = dir_q;
    pullup_d    = pullup_q;
    analog_d    = analog_q;
    irq_msk_d   = irq_msk_q;
    irq_st_d    = irq_st_q;
    edge_prev_d = irq_lvl;
    prdata_d    = prdata;
    pslverr_d   = 1'b0;
    pready_d    = access;
    if (wr) begin
      case (paddr)
        SPL_OFF_DATA:    latch_d   = pwdata[7:0];
        SPL_OFF_DIR:     dir_d     = pwdata[7:0];
        SPL_OFF_PULLUP:  pullup_d  = pwdata[7:0];
        SPL_OFF_ANALOG:  analog_d  = pwdata[3:0];
        SPL_OFF_IRQ_MSK: irq_msk_d = pwdata[1:0];
        SPL_OFF_IRQ_ST, SPL_OFF_OPTION, SPL_OFF_PINS: ;
        default:         pslverr_d = 1'b1;
      endcase
    end
    if (rd) begin
      prdata_d = SPL_ERR_NONE;
      case (paddr)
        SPL_OFF_DATA:    prdata_d[7:0] = pin_view;
        SPL_OFF_DIR:     prdata_d[7:0] = dir_q;
        SPL_OFF_PULLUP:  prdata_d[7:0] = pullup_q;
        SPL_OFF_ANALOG:  prdata_d[3:0] = analog_q;
        SPL_OFF_OPTION: begin
          prdata_d[SPL_POS_OPT_PORT] = port_mode_q;
          prdata_d[SPL_POS_BOOTED]   = (st_q == SPL_ST_RUN);
        end
        SPL_OFF_IRQ_ST: begin
          prdata_d[1:0] = irq_st_q;
          irq_st_d      = 2'b00;
        end
        SPL_OFF_IRQ_MSK: prdata_d[1:0] = irq_msk_q;
        SPL_OFF_PINS:    prdata_d[7:0] = pin_sync;
        default:         pslverr_d     = 1'b1;
      endcase
    end
    // level change sets flag; set wins over read clear
    irq_st_d = irq_st_d | (irq_lvl ^ edge_prev_q);
  end

  // ****************************************************
  // Pad drive
  // ****************************************************
  always_comb begin
    conv_d = analog_q;
    oe_d   = ~dir_q & ~{4'h0, analog_q};
    out_d  = latch_q & oe_d;
    pu_d   = pullup_q & dir_q & ~{4'h0, analog_q};
    pd_d   = (st_q == SPL_ST_HOLD) ? 2'b11 : 2'b00;
    core_d = (st_d == SPL_ST_RUN);
    irq_d  = |(irq_st_d & ~irq_msk_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q      <= SPL_RST_DATA;
      dir_q        <= SPL_RST_DIR;
      pullup_q     <= SPL_RST_PULLUP;
      analog_q     <= SPL_RST_ANALOG;
      port_mode_q  <= 1'b0;
      irq_st_q     <= SPL_RST_IRQ;
      irq_msk_q    <= SPL_RST_IRQ;
      edge_prev_q  <= SPL_RST_IRQ;
      st_q         <= SPL_ST_HOLD;
      prdata       <= SPL_ERR_NONE;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      pin_out      <= 8'h00;
      pin_oe       <= 8'h00;
      pin_pullup   <= 8'h00;
      pin_pulldown <= 2'b11;
      converter_select <= 4'h0;
      core_reset_n <= 1'b0;
      irq          <= 1'b0;
    end else begin
      latch_q      <= latch_d;
      dir_q        <= dir_d;
      pullup_q     <= pullup_d;
      analog_q     <= analog_d;
      port_mode_q  <= port_mode_d;
      irq_st_q     <= irq_st_d;
      irq_msk_q    <= irq_msk_d;
      edge_prev_q  <= edge_prev_d;
      st_q         <= st_d;
      prdata       <= prdata_d;
      pready       <= pready_d;
      pslverr      <= pslverr_d;
      pin_out      <= out_d;
      pin_oe       <= oe_d;
      pin_pullup   <= pu_d;
      pin_pulldown <= pd_d;
      converter_select <= conv_d;
      core_reset_n <= core_d;
      irq          <= irq_d;
    end
  end
endmodule // spl_port
`default_nettype wire

// file: rtl/spl_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module spl_sync
  import spl_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] level_q
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  logic [W-1:0] level_d;

  // A change is taken only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end else begin
      s1_q    <= async_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end
endmodule // spl_sync
`default_nettype wire

// file: tb/spl_board.sv
// Board model that resolves the level of each port pin
`default_nettype none
module spl_board (
  input  wire logic       pclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [1:0] pin_pulldown,
  input  wire logic [7:0] ext_drive,
  input  wire logic [7:0] ext_val,
  output var  logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // A floating pin wanders so no settled value can pass by luck
  logic float_q = 1'b0;
  always @(posedge pclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_drive[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else if (i == 2 || i == 3) pin_in[i] = !pin_pulldown[i - 2] && float_q;
      else pin_in[i] = float_q;
    end
  end
endmodule // spl_board
`default_nettype wire

// file: tb/spl_checker.sv
// Assertions on the shared port pin ports
`default_nettype none
module spl_checker
  import spl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  option_byte,
  input wire logic        option_valid,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pin_pullup,
  input wire logic [1:0]  pin_pulldown,
  input wire logic [3:0]  converter_select,
  input wire logic        core_reset_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pull_down; $rose(presetn) |-> pin_pulldown == 2'b11; endproperty
  a_pull_down: assert property (p_pull_down) else $error("pull-down gone at release");
  property p_rst_pin; (!option_byte[0] && !pin_in[4])[*8] |-> !core_reset_n; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("low reset pin ignored");
  property p_port_keep; option_byte[0] && core_reset_n |=> core_reset_n; endproperty
  a_port_keep: assert property (p_port_keep) else $error("port mode pin reset the core");
  property p_hold; !core_reset_n && !option_valid |=> !core_reset_n; endproperty
  a_hold: assert property (p_hold) else $error("core left reset before option read");
  property p_ana_oe; (converter_select & pin_oe[3:0]) == 4'h0; endproperty
  a_ana_oe: assert property (p_ana_oe) else $error("analog pin still driven");
  property p_ana_pu; (converter_select & pin_pullup[3:0]) == 4'h0; endproperty
  a_ana_pu: assert property (p_ana_pu) else $error("analog pin pulled up");
  property p_pu_in; (pin_pullup & pin_oe) == 8'h00; endproperty
  a_pu_in: assert property (p_pu_in) else $error("pull-up on output pin");
  // Latch lands at the access edge, the registered pads one edge later
  property p_data; psel && penable && !pready && pwrite && paddr == SPL_OFF_DATA
    |-> ##2 ((pin_out ^ $past(pwdata[7:0], 2)) & pin_oe) == 8'h00; endproperty
  a_data: assert property (p_data) else $error("output pins differ from written byte");
  property p_ready; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("pready not a one-cycle answer");
  property p_err; psel && penable && !pready |=> pslverr == (paddr > SPL_OFF_PINS); endproperty
  a_err: assert property (p_err) else $error("error response wrong");
endmodule // spl_checker
bind spl_port spl_checker spl_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .option_byte, .option_valid, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_pulldown, .converter_select,
  .core_reset_n);
`default_nettype wire

// file: tb/spl_port_tb.sv
// Self-checking bench of the shared port pin logic
`default_nettype none
module spl_port_tb
  import spl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, option_valid = 1'b0;
  logic        pready, pslverr, core_reset_n, irq;
  logic [7:0]  paddr = 8'h00, option_byte = 8'h00, ext_val = 8'h50, ext_drive = 8'hFF;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  pin_pulldown;
  logic [3:0]  converter_select;
  int          num_errors = 0, comparisons = 0;
  always #12.5 pclk = ~pclk;
  spl_port spl_port_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .option_byte, .option_valid, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_pulldown, .converter_select,
    .core_reset_n, .irq);
  spl_board spl_board_inst (.pclk, .pin_out, .pin_oe, .pin_pullup, .pin_pulldown, .ext_drive, .ext_val, .pin_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) num_errors++;
    rd = prdata;
    chk(32'(pslverr), 32'(err));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, exp);
  endtask
  task automatic wait_core(input logic v);
    for (int n = 0; n < 40 && core_reset_n !== v; n++) @(posedge pclk);
    chk(32'(core_reset_n), 32'(v));
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    chk(32'(pin_pulldown), 32'h3);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(32'({pin_pulldown, core_reset_n}), 32'h0);
    // Pin low and settled through the synchroniser before the option byte turns readable
    ext_val      <= 8'h40;
    repeat (8) @(posedge pclk);
    option_valid <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(32'(core_reset_n), 32'h0);
    ext_val <= 8'h50;
    wait_core(1'b1);
    rd_chk(SPL_OFF_OPTION, 32'h2);
    apb(1'b1, 8'h20, 32'h0, 1'b1);
    // Interrupts masked before the shared pins turn to outputs
    wr(SPL_OFF_IRQ_MSK, 32'h3);
    wr(SPL_OFF_DATA, 32'h2A);
    apb(1'b0, SPL_OFF_IRQ_ST, 32'h0, 1'b0);
    wr(SPL_OFF_DIR, 32'hD0);
    repeat (6) @(posedge pclk);
    chk(32'({pin_oe, pin_out & pin_oe, irq}), 32'h5E54);
    rd_chk(SPL_OFF_DATA, 32'h7A);
    rd_chk(SPL_OFF_IRQ_ST, 32'h3);
    rd_chk(SPL_OFF_IRQ_ST, 32'h0);
    wr(SPL_OFF_IRQ_MSK, 32'h0);
    wr(SPL_OFF_DATA, 32'h28);
    repeat (6) @(posedge pclk);
    chk(32'(irq), 32'h1);
    rd_chk(SPL_OFF_IRQ_ST, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    // Single-bit set done as software would: whole byte read, modified, written
    rd_chk(SPL_OFF_DATA, 32'h78);
    wr(SPL_OFF_DATA, rd | 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(pin_out & pin_oe), 32'h29);
    wr(SPL_OFF_PULLUP, 32'h80);
    wr(SPL_OFF_ANALOG, 32'hC);
    ext_drive <= 8'h7F;
    repeat (6) @(posedge pclk);
    chk(32'({converter_select, pin_oe, pin_pullup}), 32'hC2380);
    rd_chk(SPL_OFF_PINS, 32'hF1);
    ext_val <= 8'h40;
    wait_core(1'b0);
    ext_val <= 8'h50;
    wait_core(1'b1);
    presetn     <= 1'b0;
    option_byte <= 8'h01;
    ext_drive   <= 8'hFF;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_core(1'b1);
    ext_val <= 8'h40;
    repeat (20) @(posedge pclk);
    chk(32'(core_reset_n), 32'h1);
    rd_chk(SPL_OFF_PINS, 32'h40);
    rd_chk(SPL_OFF_OPTION, 32'h3);
    test_done();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    num_errors++;
    test_done();
  end
endmodule // spl_port_tb
`default_nettype wire
